// ---- verilog/pwm_map_pkg.sv ----
// Functional notes
// - Each channel instance holds its own map of fitted words
// - Unlisted offsets in the window are reserved
// - Fine-edge phase, compare, config only when fitted
// - Fine-edge power and step on first instance
// - Fault, fine-edge, digital-compare controls need write unlock
// - Period, compares, continuous force are double buffered
// - Alias writes go through target shadow path
// - Filter offset shadowed; counters read separately
// - Capture register keeps shadow beside active value
// - Bus takes 16-bit and 32-bit writes
package pwm_map_pkg;

  localparam int WORD_W    = 16;
  localparam int ADDR_W    = 6;
  localparam int NUM_WORDS = 64;
  localparam int DATA_W    = 32;

  typedef logic [WORD_W-1:0]    word_t;
  typedef logic [ADDR_W-1:0]    offset_t;
  typedef logic [NUM_WORDS-1:0] word_mask_t;

  localparam offset_t OFF_TB_CONTROL     = 6'h00;
  localparam offset_t OFF_TB_STATUS      = 6'h01;
  localparam offset_t OFF_PHASE_FINE     = 6'h02;
  localparam offset_t OFF_TB_PHASE       = 6'h03;
  localparam offset_t OFF_TB_COUNTER     = 6'h04;
  localparam offset_t OFF_TB_PERIOD      = 6'h05;
  localparam offset_t OFF_PERIOD_FINE    = 6'h06;
  localparam offset_t OFF_CMP_CONTROL    = 6'h07;
  localparam offset_t OFF_COMPARE_A_VALUE_FINE      = 6'h08;
  localparam offset_t OFF_COMPARE_A_VALUE_VALUE     = 6'h09;
  localparam offset_t OFF_COMPARE_B_VALUE_VALUE     = 6'h0a;
  localparam offset_t OFF_ACT_CTRL_A     = 6'h0b;
  localparam offset_t OFF_ACT_CTRL_B     = 6'h0c;
  localparam offset_t OFF_ACT_SW_FORCE   = 6'h0d;
  localparam offset_t OFF_ACT_CONT_FORCE = 6'h0e;
  localparam offset_t OFF_DB_CONTROL     = 6'h0f;
  localparam offset_t OFF_DB_RISE        = 6'h10;
  localparam offset_t OFF_DB_FALL        = 6'h11;
  localparam offset_t OFF_FLT_SRC_SEL    = 6'h12;
  localparam offset_t OFF_FLT_CMP_SEL    = 6'h13;
  localparam offset_t OFF_FLT_ACTION     = 6'h14;
  localparam offset_t OFF_FLT_INT_EN     = 6'h15;
  localparam offset_t OFF_FLT_FLAGS      = 6'h16;
  localparam offset_t OFF_FLT_CLEAR      = 6'h17;
  localparam offset_t OFF_FLT_FORCE      = 6'h18;
  localparam offset_t OFF_EVT_SELECT     = 6'h19;
  localparam offset_t OFF_EVT_PRESCALE   = 6'h1a;
  localparam offset_t OFF_EVT_FLAGS      = 6'h1b;
  localparam offset_t OFF_EVT_CLEAR      = 6'h1c;
  localparam offset_t OFF_EVT_FORCE      = 6'h1d;
  localparam offset_t OFF_CHOP_CONTROL   = 6'h1e;
  localparam offset_t OFF_FINE_CONFIG    = 6'h20;
  localparam offset_t OFF_FINE_POWER     = 6'h21;
  localparam offset_t OFF_FINE_STEP      = 6'h26;
  localparam offset_t OFF_FINE_PRD_CTRL  = 6'h28;
  localparam offset_t OFF_PRD_FINE_ALIAS = 6'h2a;
  localparam offset_t OFF_PERIOD_ALIAS   = 6'h2b;
  localparam offset_t OFF_COMPARE_A_VALUE_FINE_ALS  = 6'h2c;
  localparam offset_t OFF_COMPARE_A_VALUE_ALIAS     = 6'h2d;
  localparam offset_t OFF_DC_TRIP_SEL    = 6'h30;
  localparam offset_t OFF_DC_A_CONTROL   = 6'h31;
  localparam offset_t OFF_DC_B_CONTROL   = 6'h32;
  localparam offset_t OFF_DC_FILT_CTRL   = 6'h33;
  localparam offset_t OFF_DC_CAPT_CTRL   = 6'h34;
  localparam offset_t OFF_DC_FILT_OFFSET = 6'h35;
  localparam offset_t OFF_DC_OFFSET_CNT  = 6'h36;
  localparam offset_t OFF_DC_FILT_WINDOW = 6'h37;
  localparam offset_t OFF_DC_WINDOW_CNT  = 6'h38;
  localparam offset_t OFF_DC_CAPTURE     = 6'h39;

  localparam word_t      CFG_RESET = 16'h0000;
  localparam word_mask_t ALL_WORDS = {NUM_WORDS{1'b1}};

  function automatic word_mask_t bit_at(input offset_t o);
    return word_mask_t'(1) << o;
  endfunction : bit_at

  // Listed offsets 0x00..0x1e run contiguously
  localparam word_mask_t LISTED_MASK = (bit_at(6'h1f) - word_mask_t'(1))
    | bit_at(OFF_FINE_CONFIG) | bit_at(OFF_FINE_POWER) | bit_at(OFF_FINE_STEP)
    | bit_at(OFF_FINE_PRD_CTRL) | bit_at(OFF_PRD_FINE_ALIAS) | bit_at(OFF_PERIOD_ALIAS)
    | bit_at(OFF_COMPARE_A_VALUE_FINE_ALS) | bit_at(OFF_COMPARE_A_VALUE_ALIAS) | bit_at(OFF_DC_TRIP_SEL)
    | bit_at(OFF_DC_A_CONTROL) | bit_at(OFF_DC_B_CONTROL) | bit_at(OFF_DC_FILT_CTRL)
    | bit_at(OFF_DC_CAPT_CTRL) | bit_at(OFF_DC_FILT_OFFSET) | bit_at(OFF_DC_OFFSET_CNT)
    | bit_at(OFF_DC_FILT_WINDOW) | bit_at(OFF_DC_WINDOW_CNT) | bit_at(OFF_DC_CAPTURE);
  localparam word_mask_t FINE_MASK = bit_at(OFF_PHASE_FINE) | bit_at(OFF_COMPARE_A_VALUE_FINE)
    | bit_at(OFF_FINE_CONFIG) | bit_at(OFF_COMPARE_A_VALUE_FINE_ALS);
  localparam word_mask_t FIRST_ONLY_MASK = bit_at(OFF_FINE_POWER) | bit_at(OFF_FINE_STEP);
  localparam word_mask_t PROTECT_MASK = bit_at(OFF_FLT_SRC_SEL) | bit_at(OFF_FLT_CMP_SEL)
    | bit_at(OFF_FLT_ACTION) | bit_at(OFF_FLT_INT_EN) | bit_at(OFF_FLT_CLEAR)
    | bit_at(OFF_FLT_FORCE) | FINE_MASK | FIRST_ONLY_MASK | bit_at(OFF_FINE_PRD_CTRL)
    | bit_at(OFF_DC_TRIP_SEL) | bit_at(OFF_DC_A_CONTROL) | bit_at(OFF_DC_B_CONTROL)
    | bit_at(OFF_DC_FILT_CTRL) | bit_at(OFF_DC_CAPT_CTRL);
  localparam word_mask_t LIVE_MASK = bit_at(OFF_TB_STATUS) | bit_at(OFF_FLT_FLAGS)
    | bit_at(OFF_EVT_FLAGS) | bit_at(OFF_DC_OFFSET_CNT) | bit_at(OFF_DC_WINDOW_CNT);
  localparam word_mask_t PULSE_MASK = bit_at(OFF_TB_STATUS) | bit_at(OFF_FLT_CLEAR)
    | bit_at(OFF_FLT_FORCE) | bit_at(OFF_EVT_CLEAR) | bit_at(OFF_EVT_FORCE);
  localparam word_mask_t WRITE_ONLY_MASK = PULSE_MASK & ~LIVE_MASK;
  localparam word_mask_t ALIAS_MASK = bit_at(OFF_PRD_FINE_ALIAS) | bit_at(OFF_PERIOD_ALIAS)
    | bit_at(OFF_COMPARE_A_VALUE_FINE_ALS) | bit_at(OFF_COMPARE_A_VALUE_ALIAS);

  localparam int NUM_SHADOW = 8;
  localparam int SH_PERIOD  = 0;
  localparam int SH_CAPTURE = 7;
  localparam offset_t SHADOW_OFF [NUM_SHADOW] = '{OFF_TB_PERIOD, OFF_PERIOD_FINE,
    OFF_COMPARE_A_VALUE_FINE, OFF_COMPARE_A_VALUE_VALUE, OFF_COMPARE_B_VALUE_VALUE, OFF_ACT_CONT_FORCE,
    OFF_DC_FILT_OFFSET, OFF_DC_CAPTURE};
  localparam word_mask_t SHADOW_MASK = bit_at(OFF_TB_PERIOD) | bit_at(OFF_PERIOD_FINE)
    | bit_at(OFF_COMPARE_A_VALUE_FINE) | bit_at(OFF_COMPARE_A_VALUE_VALUE) | bit_at(OFF_COMPARE_B_VALUE_VALUE)
    | bit_at(OFF_ACT_CONT_FORCE) | bit_at(OFF_DC_FILT_OFFSET) | bit_at(OFF_DC_CAPTURE);
  localparam word_mask_t STORE_MASK = LISTED_MASK & ~LIVE_MASK & ~PULSE_MASK
    & ~SHADOW_MASK & ~ALIAS_MASK;

  function automatic offset_t alias_target(input offset_t o);
    case (o)
      OFF_PRD_FINE_ALIAS: return OFF_PERIOD_FINE;
      OFF_PERIOD_ALIAS:   return OFF_TB_PERIOD;
      OFF_COMPARE_A_VALUE_FINE_ALS:  return OFF_COMPARE_A_VALUE_FINE;
      OFF_COMPARE_A_VALUE_ALIAS:     return OFF_COMPARE_A_VALUE_VALUE;
      default:            return o;
    endcase
  endfunction : alias_target

endpackage : pwm_map_pkg

// ---- verilog/shadow_pair.sv ----
`timescale 1ns/1ns
module shadow_pair #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             load,
  output logic      [WIDTH-1:0] active_q,
  output logic      [WIDTH-1:0] shadow_q
);

  logic [WIDTH-1:0] active_d;
  logic [WIDTH-1:0] shadow_d;

  // A write in the load cycle lands in the shadow; the old shadow moves up
  always_comb begin
    shadow_d = wr_en ? wr_data : shadow_q;
    active_d = load ? shadow_q : active_q;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      active_q <= '0;
      shadow_q <= '0;
    end else begin
      active_q <= active_d;
      shadow_q <= shadow_d;
    end
  end

endmodule : shadow_pair

// ---- verilog/pwm_channel_register_map.sv ----
`timescale 1ns/1ns
module pwm_channel_register_map
  import pwm_map_pkg::*;
#(
  parameter int INSTANCE_INDEX = 0,
  parameter bit HAS_FINE_EDGE  = 1'b1
) (
  input  wire logic                             clk_sys,
  input  wire logic                             reset,
  input  wire logic                             bus_sel,
  input  wire logic                             bus_write,
  input  wire logic                             bus_size32,
  input  wire pwm_map_pkg::offset_t             bus_addr,
  input  wire logic [pwm_map_pkg::DATA_W-1:0]   bus_wdata,
  output logic      [pwm_map_pkg::DATA_W-1:0]   bus_rdata,
  output logic                                  bus_rdata_valid,
  input  wire logic                             write_protect_unlock,
  input  wire logic                             shadow_load,
  input  wire pwm_map_pkg::word_t               timebase_status_in,
  input  wire pwm_map_pkg::word_t               fault_flags_in,
  input  wire pwm_map_pkg::word_t               event_flags_in,
  input  wire pwm_map_pkg::word_t               offset_count_in,
  input  wire pwm_map_pkg::word_t               window_count_in,
  input  wire logic                             capture_strobe,
  input  wire pwm_map_pkg::word_t               capture_value,
  output logic [pwm_map_pkg::NUM_WORDS-1:0][pwm_map_pkg::WORD_W-1:0] cfg_word,
  output pwm_map_pkg::word_mask_t               write_pulse,
  output logic [pwm_map_pkg::NUM_WORDS-1:0][pwm_map_pkg::WORD_W-1:0] write_pulse_data
);

  import pwm_map_pkg::*;

  // Offsets fixed per instance at elaboration
  localparam word_mask_t IMPL_MASK = LISTED_MASK
    & (HAS_FINE_EDGE ? ALL_WORDS : ~FINE_MASK)
    & ((INSTANCE_INDEX == 0) ? ALL_WORDS : ~FIRST_ONLY_MASK);

  word_mask_t              we_raw;
  word_t                   wd_raw [NUM_WORDS];
  word_mask_t              we_ok;
  word_mask_t              we_eff;
  word_t                   wd_eff [NUM_WORDS];
  word_t                   store_q [NUM_WORDS];
  word_t                   store_d [NUM_WORDS];
  word_t                   shadow_active [NUM_SHADOW];
  word_t                   shadow_val [NUM_SHADOW];
  word_t                   rd_word [NUM_WORDS];
  logic [DATA_W-1:0]       rdata_d;
  logic                    rvalid_d;
  word_mask_t              pulse_d;
  logic [NUM_WORDS-1:0][WORD_W-1:0] pulse_data_d;
  offset_t                 base_addr;
  offset_t                 tgt;

  // 32-bit accesses align down to the even word; low half first
  assign base_addr = bus_size32 ? {bus_addr[ADDR_W-1:1], 1'b0} : bus_addr;

  // Decode the write into per-word strobes
  always_comb begin
    tgt    = '0;
    we_raw = '0;
    we_eff = '0;
    for (int i = 0; i < NUM_WORDS; i++) begin
      wd_raw[i] = '0;
      wd_eff[i] = '0;
    end
    if (bus_sel && bus_write) begin
      we_raw[base_addr] = 1'b1;
      wd_raw[base_addr] = bus_wdata[WORD_W-1:0];
      if (bus_size32) begin
        we_raw[base_addr | 6'h01] = 1'b1;
        wd_raw[base_addr | 6'h01] = bus_wdata[DATA_W-1:WORD_W];
      end
    end
    // Absent or locked words drop the write with no side effect
    we_ok = we_raw & IMPL_MASK
      & (write_protect_unlock ? ALL_WORDS : ~PROTECT_MASK);
    for (int i = 0; i < NUM_WORDS; i++) begin
      if (we_ok[i]) begin
        tgt         = alias_target(offset_t'(i));
        we_eff[tgt] = 1'b1;
        wd_eff[tgt] = wd_raw[i];
      end
    end
  end

  // Plain configuration words
  always_comb begin
    for (int i = 0; i < NUM_WORDS; i++) begin
      store_d[i] = store_q[i];
      if (we_eff[i] && STORE_MASK[i]) begin
        store_d[i] = wd_eff[i];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        store_q[i] <= CFG_RESET;
      end
    end else begin
      store_q <= store_d;
    end
  end

  // Double-buffered words; capture is filled by hardware, not by the bus
  generate
    for (genvar s = 0; s < NUM_SHADOW; s++) begin : g_shadow
      logic  sh_wr;
      word_t sh_data;
      if (s == SH_CAPTURE) begin : g_cap
        assign sh_wr   = capture_strobe;
        assign sh_data = capture_value;
      end else begin : g_bus
        assign sh_wr   = we_eff[SHADOW_OFF[s]] && IMPL_MASK[SHADOW_OFF[s]];
        assign sh_data = wd_eff[SHADOW_OFF[s]];
      end
      shadow_pair #(
        .WIDTH (WORD_W)
      ) u_shadow (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .wr_en    (sh_wr),
        .wr_data  (sh_data),
        .load     (shadow_load),
        .active_q (shadow_active[s]),
        .shadow_q (shadow_val[s])
      );
    end
  endgenerate

  // Configuration view handed to the submodules, active values only
  always_comb begin
    for (int i = 0; i < NUM_WORDS; i++) begin
      cfg_word[i] = (STORE_MASK[i] && IMPL_MASK[i]) ? store_q[i] : CFG_RESET;
    end
    for (int s = 0; s < NUM_SHADOW; s++) begin
      if (IMPL_MASK[SHADOW_OFF[s]]) begin
        cfg_word[SHADOW_OFF[s]] = shadow_active[s];
      end
    end
  end

  // Read view: aliases show the active target, write-only words read zero
  always_comb begin
    for (int i = 0; i < NUM_WORDS; i++) begin
      rd_word[i] = IMPL_MASK[alias_target(offset_t'(i))] ? cfg_word[alias_target(offset_t'(i))]
                                                      : CFG_RESET;
      if (!IMPL_MASK[i] || WRITE_ONLY_MASK[i]) begin
        rd_word[i] = CFG_RESET;
      end
    end
    rd_word[OFF_TB_STATUS]     = timebase_status_in;
    rd_word[OFF_FLT_FLAGS]     = fault_flags_in;
    rd_word[OFF_EVT_FLAGS]     = event_flags_in;
    rd_word[OFF_DC_OFFSET_CNT] = offset_count_in;
    rd_word[OFF_DC_WINDOW_CNT] = window_count_in;
  end

  // Read answer is registered one cycle after the request
  always_comb begin
    rvalid_d = bus_sel && !bus_write;
    rdata_d  = bus_rdata;
    if (rvalid_d) begin
      rdata_d = bus_size32 ? {rd_word[base_addr | 6'h01], rd_word[base_addr]}
                           : {16'h0000, rd_word[base_addr]};
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bus_rdata       <= '0;
      bus_rdata_valid <= 1'b0;
    end else begin
      bus_rdata       <= rdata_d;
      bus_rdata_valid <= rvalid_d;
    end
  end

  // Clear, force and status writes leave as one-cycle strobes
  always_comb begin
    pulse_d = we_ok & PULSE_MASK;
    for (int i = 0; i < NUM_WORDS; i++) begin
      pulse_data_d[i] = pulse_d[i] ? wd_raw[i] : write_pulse_data[i];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      write_pulse      <= '0;
      write_pulse_data <= '0;
    end else begin
      write_pulse      <= pulse_d;
      write_pulse_data <= pulse_data_d;
    end
  end

  // Checks
  logic wr16;
  logic rd16;
  logic wr32;
  assign wr16 = bus_sel && bus_write && !bus_size32;
  assign rd16 = bus_sel && !bus_write && !bus_size32;
  assign wr32 = bus_sel && bus_write && bus_size32;

  sequence s_period_shadow_write;
    wr16 && (bus_addr == OFF_TB_PERIOD) && !shadow_load;
  endsequence

  // Bus write keeps its last level when idle, so qualify by select
  sequence s_quiet_load;
    shadow_load && !(bus_sel && bus_write) && !capture_strobe;
  endsequence

  AST_READ_ANSWER: assert property (@(posedge clk_sys) disable iff (reset)
    (bus_sel && !bus_write) |=> bus_rdata_valid)
    else $error("read answer missing");

  AST_READ_PULSE: assert property (@(posedge clk_sys) disable iff (reset)
    !(bus_sel && !bus_write) |=> !bus_rdata_valid)
    else $error("read answer without request");

  AST_RESERVED_READ: assert property (@(posedge clk_sys) disable iff (reset)
    (rd16 && !IMPL_MASK[bus_addr]) |=> (bus_rdata == 32'h0000_0000))
    else $error("reserved word read nonzero");

  AST_RESERVED_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
    (wr16 && !IMPL_MASK[bus_addr] && !shadow_load) |=> $stable(cfg_word) && (write_pulse == '0))
    else $error("reserved write had an effect");

  AST_FINE_ABSENT: assert property (@(posedge clk_sys) disable iff (reset)
    (!HAS_FINE_EDGE && rd16 && bus_addr == OFF_FINE_CONFIG) |=> bus_rdata == 32'h0000_0000)
    else $error("absent fine-edge config readable");

  AST_FIRST_ONLY: assert property (@(posedge clk_sys) disable iff (reset)
    (INSTANCE_INDEX != 0) |-> (cfg_word[OFF_FINE_POWER] == 16'h0000)
      && (cfg_word[OFF_FINE_STEP] == 16'h0000))
    else $error("first-instance word present elsewhere");

  AST_LOCKED_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
    (wr16 && bus_addr == OFF_FLT_ACTION && !write_protect_unlock)
      |=> $stable(cfg_word[OFF_FLT_ACTION]))
    else $error("protected word written while locked");

  AST_UNLOCKED_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
    (wr16 && bus_addr == OFF_FLT_ACTION && write_protect_unlock)
      |=> cfg_word[OFF_FLT_ACTION] == $past(bus_wdata[15:0]))
    else $error("unlocked protected write lost");

  AST_SHADOW_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    s_period_shadow_write |=> $stable(cfg_word[OFF_TB_PERIOD])
      && shadow_val[SH_PERIOD] == $past(bus_wdata[15:0]))
    else $error("period bypassed its shadow");

  AST_SHADOW_LOAD: assert property (@(posedge clk_sys) disable iff (reset)
    s_quiet_load |=> cfg_word[OFF_TB_PERIOD] == $past(shadow_val[SH_PERIOD]))
    else $error("period shadow not loaded");

  AST_ALIAS_PATH: assert property (@(posedge clk_sys) disable iff (reset)
    (wr16 && bus_addr == OFF_PERIOD_ALIAS && !shadow_load)
      |=> shadow_val[SH_PERIOD] == $past(bus_wdata[15:0]) && $stable(cfg_word[OFF_TB_PERIOD]))
    else $error("alias write missed shadow path");

  AST_COUNTER_READ: assert property (@(posedge clk_sys) disable iff (reset)
    (rd16 && bus_addr == OFF_DC_OFFSET_CNT) |=> bus_rdata[15:0] == $past(offset_count_in))
    else $error("offset counter read wrong");

  AST_CAPTURE_SHADOW: assert property (@(posedge clk_sys) disable iff (reset)
    (capture_strobe && !shadow_load) |=> shadow_val[SH_CAPTURE] == $past(capture_value)
      && $stable(cfg_word[OFF_DC_CAPTURE]))
    else $error("capture shadow not transferred");

  AST_WIDE_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
    (wr32 && bus_addr == OFF_DB_RISE) |=> cfg_word[OFF_DB_RISE] == $past(bus_wdata[15:0])
      && cfg_word[OFF_DB_FALL] == $past(bus_wdata[31:16]))
    else $error("32-bit write split wrong");

endmodule : pwm_channel_register_map

// ---- verif/bus_master_model.sv ----
`timescale 1ns/1ns
module bus_master_model (
  input  wire logic                           clk_sys,
  output logic                                bus_sel,
  output logic                                bus_write,
  output logic                                bus_size32,
  output pwm_map_pkg::offset_t                bus_addr,
  output logic      [pwm_map_pkg::DATA_W-1:0] bus_wdata,
  input  wire logic [pwm_map_pkg::DATA_W-1:0] bus_rdata,
  input  wire logic                           bus_rdata_valid
);
  import pwm_map_pkg::*;

  initial begin
    bus_sel    = 1'b0;
    bus_write  = 1'b0;
    bus_size32 = 1'b0;
    bus_addr   = '0;
    bus_wdata  = '0;
  end

  // Request held from launch edge to the edge that takes it
  task automatic access(input logic wr, input logic sz32, input offset_t a,
                        input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    bus_sel    <= 1'b1;
    bus_write  <= wr;
    bus_size32 <= sz32;
    bus_addr   <= a;
    bus_wdata  <= d;
    @(posedge clk_sys);
    bus_sel   <= 1'b0;
    // Released address and data lines flip so a stale value never looks current
    bus_addr  <= ~a;
    bus_wdata <= ~d;
  endtask : access

  task automatic write_word(input logic sz32, input offset_t a, input logic [DATA_W-1:0] d);
    access(1'b1, sz32, a, d);
  endtask : write_word

  task automatic read_word(input logic sz32, input offset_t a, output logic [DATA_W-1:0] d);
    access(1'b0, sz32, a, '0);
    #1;
    d = (bus_rdata_valid === 1'b1) ? bus_rdata : 'x;
  endtask : read_word
endmodule : bus_master_model

// ---- verif/tb_pwm_channel_register_map.sv ----
`timescale 1ns/1ns
module tb_pwm_channel_register_map;
  import pwm_map_pkg::*;

  logic                              clk_sys = 1'b0;
  logic                              reset = 1'b1;
  logic                              write_protect_unlock = 1'b0;
  logic                              shadow_load = 1'b0;
  logic                              capture_strobe = 1'b0;
  word_t                             capture_value = 16'h0bad;
  word_t                             st_in = 16'h1111;
  word_t                             fl_in = 16'h2222;
  word_t                             ev_in = 16'h3333;
  word_t                             oc_in = 16'h4444;
  word_t                             wc_in = 16'h5555;
  logic                              bus_sel;
  logic                              bus_write;
  logic                              bus_size32;
  offset_t                           bus_addr;
  logic [DATA_W-1:0]                 bus_wdata;
  logic [DATA_W-1:0]                 rdata_u;
  logic [DATA_W-1:0]                 rdata_b;
  logic [DATA_W-1:0]                 got;
  logic                              valid_u;
  logic [NUM_WORDS-1:0][WORD_W-1:0]  cfg_u;
  logic [NUM_WORDS-1:0][WORD_W-1:0]  pdat_u;
  word_mask_t                        pulse_u;
  int                                mismatches = 0;
  int                                num_checks = 0;
  int                                pulses [NUM_WORDS];

  always #10 clk_sys = ~clk_sys;

  bus_master_model cpu_u (.clk_sys(clk_sys), .bus_sel(bus_sel), .bus_write(bus_write),
    .bus_size32(bus_size32), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(rdata_u), .bus_rdata_valid(valid_u));

  pwm_channel_register_map #(.INSTANCE_INDEX(0), .HAS_FINE_EDGE(1'b1)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .bus_sel(bus_sel), .bus_write(bus_write),
    .bus_size32(bus_size32), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(rdata_u), .bus_rdata_valid(valid_u),
    .write_protect_unlock(write_protect_unlock), .shadow_load(shadow_load),
    .timebase_status_in(st_in), .fault_flags_in(fl_in), .event_flags_in(ev_in),
    .offset_count_in(oc_in), .window_count_in(wc_in), .capture_strobe(capture_strobe),
    .capture_value(capture_value), .cfg_word(cfg_u), .write_pulse(pulse_u),
    .write_pulse_data(pdat_u));

  // Later instance without the fine-edge extension
  pwm_channel_register_map #(.INSTANCE_INDEX(1), .HAS_FINE_EDGE(1'b0)) dut_b (
    .clk_sys(clk_sys), .reset(reset), .bus_sel(bus_sel), .bus_write(bus_write),
    .bus_size32(bus_size32), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(rdata_b), .bus_rdata_valid(),
    .write_protect_unlock(write_protect_unlock), .shadow_load(shadow_load),
    .timebase_status_in(st_in), .fault_flags_in(fl_in), .event_flags_in(ev_in),
    .offset_count_in(oc_in), .window_count_in(wc_in), .capture_strobe(capture_strobe),
    .capture_value(capture_value), .cfg_word(), .write_pulse(), .write_pulse_data());

  always @(posedge clk_sys) begin
    for (int i = 0; i < NUM_WORDS; i++) begin
      if (pulse_u[i] === 1'b1) begin
        pulses[i]++;
      end
    end
  end

  function automatic word_t val(input int o);
    return {2'b10, 6'(o), 8'h5a};
  endfunction : val

  // Aliases land last in the sweep, so they own the shared shadows
  function automatic word_t exp_rd(input int o, input bit fine, input bit first, input bit lock);
    case (o)
      'h01: return st_in;
      'h16: return fl_in;
      'h1b: return ev_in;
      'h36: return oc_in;
      'h38: return wc_in;
      'h05, 'h2b: return val('h2b);
      'h06, 'h2a: return val('h2a);
      'h09, 'h2d: return val('h2d);
      'h08, 'h2c: return (fine && !lock) ? val('h2c) : '0;
      'h39: return 16'hc0de;
      'h02, 'h20: return (fine && !lock) ? val(o) : '0;
      'h21, 'h26: return (first && !lock) ? val(o) : '0;
      'h12, 'h13, 'h14, 'h15, 'h28, 'h30, 'h31, 'h32, 'h33, 'h34:
        return lock ? '0 : val(o);
      'h17, 'h18, 'h1c, 'h1d, 'h1f, 'h22, 'h23, 'h24, 'h25, 'h27, 'h29, 'h2e, 'h2f:
        return '0;
      default: return (o > 'h39) ? '0 : val(o);
    endcase
  endfunction : exp_rd

  task automatic chk(input string name, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] seen);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic summarize;
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic load_shadows;
    @(posedge clk_sys);
    shadow_load <= 1'b1;
    @(posedge clk_sys);
    shadow_load <= 1'b0;
  endtask : load_shadows

  // Upper half carries junk that a 16-bit write must ignore
  task automatic sweep;
    for (int o = 0; o < NUM_WORDS; o++) begin
      cpu_u.write_word(1'b0, offset_t'(o), {~val(o), val(o)});
    end
  endtask : sweep

  task automatic check_all(input bit lock);
    for (int o = 0; o < NUM_WORDS; o++) begin
      cpu_u.read_word(1'b0, offset_t'(o), got);
      chk($sformatf("first word %0h", o), {16'h0, exp_rd(o, 1, 1, lock)}, got);
      chk($sformatf("other word %0h", o), {16'h0, exp_rd(o, 0, 0, lock)}, rdata_b);
    end
  endtask : check_all

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    sweep();
    @(posedge clk_sys);
    capture_strobe <= 1'b1;
    capture_value  <= 16'hc0de;
    @(posedge clk_sys);
    capture_strobe <= 1'b0;
    cpu_u.read_word(1'b0, OFF_DC_CAPTURE, got);
    chk("capture before load", '0, got);
    cpu_u.read_word(1'b0, OFF_TB_PERIOD, got);
    chk("period before load", '0, got);
    load_shadows();
    check_all(1'b1);
    @(posedge clk_sys);
    write_protect_unlock <= 1'b1;
    st_in <= 16'h1a1a;
    fl_in <= 16'h2b2b;
    ev_in <= 16'h3c3c;
    oc_in <= 16'h4d4d;
    wc_in <= 16'h5e5e;
    sweep();
    load_shadows();
    check_all(1'b0);
    cpu_u.write_word(1'b1, OFF_DB_RISE, 32'hbeef_1234);
    cpu_u.read_word(1'b1, OFF_DB_RISE, got);
    chk("pair read", 32'hbeef_1234, got);
    cpu_u.read_word(1'b0, OFF_DB_FALL, got);
    chk("upper word", 32'h0000_beef, got);
    cpu_u.write_word(1'b0, OFF_COMPARE_B_VALUE_VALUE, 32'h0000_7777);
    cpu_u.read_word(1'b0, OFF_COMPARE_B_VALUE_VALUE, got);
    chk("compare b before load", {16'h0, val('h0a)}, got);
    chk("compare b active", {16'h0, val('h0a)}, {16'h0, cfg_u[OFF_COMPARE_B_VALUE_VALUE]});
    load_shadows();
    cpu_u.read_word(1'b0, OFF_COMPARE_B_VALUE_VALUE, got);
    chk("compare b after load", 32'h0000_7777, got);
    for (int o = 0; o < NUM_WORDS; o++) begin
      chk($sformatf("strobes word %0h", o), (o inside {'h01, 'h1c, 'h1d}) ? 2 :
          (o inside {'h17, 'h18}) ? 1 : 0, pulses[o]);
    end
    chk("clear strobe data", {16'h0, val('h17)}, {16'h0, pdat_u[OFF_FLT_CLEAR]});
    summarize();
  end
endmodule : tb_pwm_channel_register_map
